/* rtl/ata_read_command_engine.sv */
// task-file read command engine with its sector word fifo
//
// Behaviour
// - idle immediate: busy, idle, unbusy, interrupt
// - geometry command loads sectors and heads
// - unit/head: bits7,5 one, LOGICAL_BLOCK_ADDRESSING, drive, nibble
// - address bytes form block address 23..0
// - reads move 1..256 sectors, zero means 256
// - DMA read: busy, fill buffer, then request
// - DMA request while data; strobe per word
// - DMA read interrupts only at end/error
// - registers hold last sector on success
// - error stops at failing sector address, multiple at block end
// - byte mode aborts DMA read
// - multiple read: blocks, interrupt per block
// - data request and interrupt per block start
// - full blocks then remainder partial block
// - unprogrammed or disabled multiple aborts
// - block error posted, block still moves
// - only correctable errors continue blocks
// - faulty sector data stays readable
// - single read: per-sector fill, request, interrupt

////////////////////////////////////////////////////////////////////////////////

module sector_fifo #(
	parameter int WIDTH = 18,	// word width
	parameter int DEPTH = 8	// words held
) (
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	input  wire logic             flush,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];	// word storage
	logic [AW-1:0]    wr_q;	// write pointer
	logic [AW-1:0]    rd_q;	// read pointer
	logic [AW:0]      cnt_q;	// words held
	logic [AW:0]      cnt_d;
	logic             full_q;	// registered so ready is a clean flop
	wire              push = in_valid & ~full_q;
	wire              pop  = out_valid & out_ready;
	assign cnt_d     = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	assign in_ready  = ~full_q;
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem[rd_q];
	// storage is not reset, only the pointers and fill level
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
	end
	// pointers and fill level
	always_ff @(posedge core_clk) begin
		if (!rst_n || flush) begin
			wr_q   <= '0;
			rd_q   <= '0;
			cnt_q  <= '0;
			full_q <= 1'b0;
		end else begin
			wr_q   <= push ? AW'(wr_q + 1'b1) : wr_q;
			rd_q   <= pop ? AW'(rd_q + 1'b1) : rd_q;
			cnt_q  <= cnt_d;
			full_q <= (cnt_d == (AW+1)'(DEPTH));
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////

module ata_read_command_engine
	import ata_read_pkg::*;
#(
	parameter int FIFO_DEPTH = 8	// sector buffer words
) (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic [2:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_wdata,
	output logic      [15:0] reg_rdata_q,
	input  wire logic        byte_mode_en,
	input  wire logic [7:0]  multi_block_size,
	output logic             dma_request_q,
	input  wire logic        dma_acknowledge_n,
	input  wire logic        read_strobe_n,
	output logic      [15:0] dma_data_q,
	output logic             intrq_q,
	output logic             idle_state_q,
	output logic             fetch_req_q,
	output logic      [27:0] fetch_addr_q,
	input  wire logic        media_valid,
	input  wire media_word_t media_word,
	output logic             media_ready_q
);
	// next address after one sector, block or cylinder/head/sector
	function automatic taskaddr_t next_addr(input taskaddr_t a, input logic logical_block_addressing,
			input logic [7:0] spt, input logic [3:0] max_head);
		taskaddr_t n;
		n = a;
		if (logical_block_addressing) begin
			n = taskaddr_t'(a + 28'h000_0001);
		end else if (a.sec != spt) begin
			n.sec = a.sec + 8'h01;
		end else begin
			n.sec = 8'h01;
			if (a.head != max_head) begin
				n.head = a.head + 4'h1;
			end else begin
				n.head = 4'h0;
				{n.cyl_hi, n.cyl_lo} = {a.cyl_hi, a.cyl_lo} + 16'h0001;
			end
		end
		return n;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// task-file and control state
	state_t      state_q;	// sequencer state
	rmode_t      mode_q;	// read flavour in progress
	taskaddr_t   addr_q;	// current sector address
	logic [7:0]  sec_cnt_q;	// transfer_sector_total
	logic        lba_q;	// addressing mode bit
	logic        drive_q;	// drive select bit
	logic [7:0]  spt_q;	// sectors per track
	logic [3:0]  max_head_q;	// highest head index
	logic        busy_q, drq_q, err_q, corr_q, abrt_q, unc_q;
	logic [8:0]  sec_left_q;	// sectors still to move
	logic [7:0]  blk_left_q;	// sectors left in this block
	logic [7:0]  wcnt_q;	// words moved in this sector
	logic        sec_err_q, sec_corr_q;	// error seen on current sector
	logic        blk_stop_q;	// uncorrectable error inside block
	logic [2:0]  ack_sync_q, stb_sync_q;	// two sync stages plus history
	logic        ready_q;	// never driven or read; the media sees media_ready_q

	// fifo hookup
	logic        fifo_valid, fifo_in_ready;
	media_word_t fifo_head;
	logic        flush;

	// bus decode
	wire cmd_wr   = reg_wr && reg_addr == OFS_CMD && !busy_q;
	wire tf_wr    = reg_wr && !busy_q && !drq_q;
	wire stat_rd  = reg_rd && reg_addr == OFS_CMD;
	wire op_idle  = reg_wdata == OP_IDLE_IMM_A || reg_wdata == OP_IDLE_IMM_B;
	wire op_geom  = reg_wdata == OP_INIT_GEOM;
	wire op_dma   = reg_wdata == OP_READ_DMA;
	wire op_multi = reg_wdata == OP_READ_MULTI;
	wire op_sec   = reg_wdata == OP_READ_SEC_A || reg_wdata == OP_READ_SEC_B;
	// byte mode and an unset block size refuse their commands
	wire refuse   = (op_dma && byte_mode_en) || (op_multi && multi_block_size == '0);
	wire start_rd = cmd_wr && (op_dma || op_multi || op_sec) && !refuse;
	wire abort    = cmd_wr && !op_idle && !op_geom && !start_rd;

	// word movement: register read for pio, strobe release for dma
	wire in_xfer  = state_q == S_XFER;
	wire stb_rise = stb_sync_q[1] & ~stb_sync_q[2];
	wire dma_pop  = in_xfer && mode_q == M_DMA && !ack_sync_q[1] && stb_rise;
	wire pio_pop  = in_xfer && mode_q != M_DMA && drq_q && reg_rd && reg_addr == OFS_DATA;
	wire pop      = (dma_pop || pio_pop) && fifo_valid;
	wire sec_end  = pop && wcnt_q == WORDS_LAST;
	wire last_sec = sec_left_q == 9'h001;
	wire any_err  = sec_err_q | fifo_head.err;
	wire hard_err = any_err & ~(sec_corr_q | fifo_head.corr);
	// what happens at the end of a sector
	wire stop_now = (mode_q == M_DMA && hard_err) || (mode_q == M_SINGLE && any_err);
	wire blk_end  = blk_left_q == 8'h01;
	wire stop_blk = mode_q == M_MULTI && blk_end && (blk_stop_q || hard_err);
	wire finish   = sec_end && (last_sec || stop_now || stop_blk);
	wire advance  = sec_end && !finish;
	// single reads and block starts go back to busy, others keep streaming
	wire rebusy   = advance && (mode_q == M_SINGLE || (mode_q == M_MULTI && blk_end));
	wire go_xfer  = state_q == S_FETCH && fifo_valid;
	wire dma_req_d = in_xfer && mode_q == M_DMA && fifo_valid && !finish;
	wire int_set  = (state_q == S_IDLE_IMM) || abort || (cmd_wr && op_geom)
		|| (go_xfer && mode_q != M_DMA) || (finish && mode_q == M_DMA && !stop_now)
		|| (finish && mode_q == M_DMA && stop_now);
	assign flush  = finish || abort;

	// readback of the task file
	wire [7:0] status_v = {busy_q, ~busy_q, 2'b00, drq_q, corr_q, 1'b0, err_q};
	wire [7:0] error_v  = {1'b0, unc_q, 3'b000, abrt_q, 2'b00};
	wire [7:0] dh_v     = {1'b1, lba_q, 1'b1, drive_q, addr_q.head};
	logic [15:0] rd_mux;
	always_comb begin
		case (reg_addr)
			OFS_DATA:     rd_mux = fifo_head.data;
			OFS_FEATURE:  rd_mux = {8'h00, error_v};
			OFS_SEC_CNT:  rd_mux = {8'h00, sec_cnt_q};
			OFS_SEC_NUM:  rd_mux = {8'h00, addr_q.sec};
			OFS_CYL_LO:   rd_mux = {8'h00, addr_q.cyl_lo};
			OFS_CYL_HI:   rd_mux = {8'h00, addr_q.cyl_hi};
			OFS_DEV_HEAD: rd_mux = {8'h00, dh_v};
			default:      rd_mux = {8'h00, status_v};
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers; only stage two and later feed logic
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ack_sync_q <= 3'b111;
			stb_sync_q <= 3'b111;
		end else begin
			ack_sync_q <= {ack_sync_q[1:0], dma_acknowledge_n};
			stb_sync_q <= {stb_sync_q[1:0], read_strobe_n};
		end
	end

	// sequencer
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_q <= S_IDLE;
			mode_q  <= M_SINGLE;
		end else begin
			case (state_q)
				S_IDLE: begin
					if (cmd_wr && op_idle) begin
						state_q <= S_IDLE_IMM;
					end else if (start_rd) begin
						state_q <= S_FETCH;
						mode_q  <= op_dma ? M_DMA : (op_multi ? M_MULTI : M_SINGLE);
					end
				end
				S_IDLE_IMM: state_q <= S_IDLE;
				S_FETCH:    state_q <= fifo_valid ? S_XFER : S_FETCH;
				S_XFER: begin
					if (finish) begin
						state_q <= S_DONE;
					end else if (rebusy) begin
						state_q <= S_FETCH;
					end
				end
				S_DONE:     state_q <= S_IDLE;
				default:    state_q <= S_IDLE;
			endcase
		end
	end

	// task-file registers, host writes and device updates
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			addr_q     <= '0;
			sec_cnt_q  <= '0;
			lba_q      <= 1'b0;
			drive_q    <= 1'b0;
			spt_q      <= DEF_SPT;
			max_head_q <= DEF_MAX_HEAD;
		end else begin
			if (tf_wr && reg_addr == OFS_SEC_CNT) sec_cnt_q <= reg_wdata;
			if (tf_wr && reg_addr == OFS_SEC_NUM) addr_q.sec <= reg_wdata;
			if (tf_wr && reg_addr == OFS_CYL_LO) addr_q.cyl_lo <= reg_wdata;
			if (tf_wr && reg_addr == OFS_CYL_HI) addr_q.cyl_hi <= reg_wdata;
			if (tf_wr && reg_addr == OFS_DEV_HEAD) begin
				addr_q.head <= reg_wdata[3:0];
				lba_q       <= reg_wdata[DH_LBA];
				drive_q     <= reg_wdata[DH_DRIVE];
			end
			if (cmd_wr && op_geom) begin
				spt_q      <= sec_cnt_q;
				max_head_q <= addr_q.head;
			end
			// the sector that ends the read stays in place, others step on
			if (advance) addr_q <= next_addr(addr_q, lba_q, spt_q, max_head_q);
		end
	end

	// counters for sectors, blocks and words
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sec_left_q <= '0;
			blk_left_q <= '0;
			wcnt_q     <= '0;
		end else begin
			if (start_rd) begin
				sec_left_q <= (sec_cnt_q == '0) ? FULL_COUNT : {1'b0, sec_cnt_q};
				blk_left_q <= multi_block_size;
				wcnt_q     <= '0;
			end else begin
				if (pop) wcnt_q <= wcnt_q + 8'h01;
				if (advance) begin
					sec_left_q <= sec_left_q - 9'h001;
					blk_left_q <= blk_end ? multi_block_size : blk_left_q - 8'h01;
				end
			end
		end
	end

	// status, error and interrupt flags
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			busy_q <= 1'b0; drq_q <= 1'b0; err_q <= 1'b0; corr_q <= 1'b0;
			abrt_q <= 1'b0; unc_q <= 1'b0; intrq_q <= 1'b0; idle_state_q <= 1'b0;
			sec_err_q <= 1'b0; sec_corr_q <= 1'b0; blk_stop_q <= 1'b0;
		end else begin
			// busy covers idle entry, command start and every return to S_FETCH
			busy_q <= (cmd_wr && (op_idle || start_rd)) || (go_xfer ? 1'b0 : busy_q && state_q
				== S_FETCH) || rebusy;
			drq_q  <= go_xfer || (drq_q && in_xfer && !finish && !rebusy);
			if (cmd_wr) begin
				err_q <= abort; abrt_q <= abort; unc_q <= 1'b0; corr_q <= 1'b0;
				idle_state_q <= op_idle;
			end else if (go_xfer && any_err) begin
				err_q  <= hard_err; unc_q <= hard_err; corr_q <= ~hard_err;
			end else if (sec_end && any_err) begin
				err_q  <= hard_err; unc_q <= hard_err; corr_q <= ~hard_err;
			end
			// per-sector error memory, refreshed as each sector starts
			sec_err_q  <= (advance || start_rd) ? 1'b0 : any_err && (go_xfer || in_xfer);
			sec_corr_q <= (advance || start_rd) ? 1'b0 : sec_corr_q | (pop & fifo_head.corr);
			blk_stop_q <= (start_rd || (advance && blk_end)) ? 1'b0 : blk_stop_q | (pop & hard_err);
			// a new event wins over the clear by status read
			intrq_q <= int_set || (intrq_q && !stat_rd && !cmd_wr);
		end
	end

	// flopped outputs toward the pins and the media side
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			reg_rdata_q   <= '0;
			dma_request_q <= 1'b0;
			dma_data_q    <= '0;
			fetch_req_q   <= 1'b0;
			fetch_addr_q  <= '0;
			media_ready_q <= 1'b0;
		end else begin
			reg_rdata_q   <= reg_rd ? rd_mux : reg_rdata_q;
			dma_request_q <= dma_req_d;
			dma_data_q    <= fifo_head.data; // head stays put until strobe release
			fetch_req_q   <= start_rd || advance;
			fetch_addr_q  <= advance ? 28'(next_addr(addr_q, lba_q, spt_q, max_head_q)) : 28'(addr_q);
			// ready lags the fifo by a cycle, so a word is taken at most every other cycle
			media_ready_q <= fifo_in_ready && !(media_valid && media_ready_q);
		end
	end

	sector_fifo #(.WIDTH($bits(media_word_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.flush     (flush),
		.in_valid  (media_valid && media_ready_q),
		.in_data   (media_word),
		.in_ready  (fifo_in_ready),
		.out_valid (fifo_valid),
		.out_data  (fifo_head),
		.out_ready (pop)
	);

	////////////////////////////////////////////////////////////////////////////
	// checks
	a_idle_busy_int: assert property (@(posedge core_clk) disable iff (!rst_n)
		cmd_wr && op_idle |-> ##1 busy_q ##1 (!busy_q && intrq_q && idle_state_q))
		else $error("idle immediate sequence wrong");
	a_geom_loaded: assert property (@(posedge core_clk) disable iff (!rst_n)
		cmd_wr && op_geom |=> spt_q == $past(sec_cnt_q) && max_head_q == $past(addr_q.head))
		else $error("geometry not loaded");
	a_count_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
		start_rd && sec_cnt_q == 8'h00 |=> sec_left_q == 9'h100)
		else $error("zero count not 256");
	a_dma_req_data: assert property (@(posedge core_clk) disable iff (!rst_n)
		dma_request_q |-> $past(fifo_valid) && mode_q == M_DMA)
		else $error("dma request without data");
	a_dma_one_int: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(intrq_q) && mode_q == M_DMA && !$past(cmd_wr) && !idle_state_q
		|-> state_q == S_DONE)
		else $error("dma interrupt mid transfer");
	a_byte_abort: assert property (@(posedge core_clk) disable iff (!rst_n)
		cmd_wr && op_dma && byte_mode_en |=> abrt_q && err_q && intrq_q && !busy_q)
		else $error("byte mode dma not aborted");
	a_multi_abort: assert property (@(posedge core_clk) disable iff (!rst_n)
		cmd_wr && op_multi && multi_block_size == 8'h00 |=> abrt_q && state_q == S_IDLE)
		else $error("multiple without block size accepted");
	a_drq_with_int: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(drq_q) && mode_q != M_DMA |-> intrq_q && !busy_q)
		else $error("block start without interrupt");
	a_hold_last: assert property (@(posedge core_clk) disable iff (!rst_n)
		finish |=> addr_q == $past(addr_q))
		else $error("address moved past last sector");
	c_dma_done:   cover property (@(posedge core_clk) state_q == S_DONE && mode_q == M_DMA);
	c_multi_blk:  cover property (@(posedge core_clk) rebusy && mode_q == M_MULTI);
	c_media_err:  cover property (@(posedge core_clk) sec_end && any_err);
endmodule

/* rtl/ata_read_pkg.sv */
// shared constants, types and states of the read command engine
package ata_read_pkg;
	// task-file register offsets
	localparam logic [2:0]  OFS_DATA     = 3'h0;	// data word port
	localparam logic [2:0]  OFS_FEATURE  = 3'h1;	// write feature, read error
	localparam logic [2:0]  OFS_SEC_CNT  = 3'h2;	// transfer_sector_total
	localparam logic [2:0]  OFS_SEC_NUM  = 3'h3;	// start_sector_index
	localparam logic [2:0]  OFS_CYL_LO   = 3'h4;	// track_index_low
	localparam logic [2:0]  OFS_CYL_HI   = 3'h5;	// track_index_high
	localparam logic [2:0]  OFS_DEV_HEAD = 3'h6;	// unit_and_head_select
	localparam logic [2:0]  OFS_CMD      = 3'h7;	// write opcode, read status
	// opcodes
	localparam logic [7:0]  OP_IDLE_IMM_A = 8'h95;
	localparam logic [7:0]  OP_IDLE_IMM_B = 8'hE1;
	localparam logic [7:0]  OP_INIT_GEOM  = 8'h91;
	localparam logic [7:0]  OP_READ_DMA   = 8'hC8;
	localparam logic [7:0]  OP_READ_MULTI = 8'hC4;
	localparam logic [7:0]  OP_READ_SEC_A = 8'h20;
	localparam logic [7:0]  OP_READ_SEC_B = 8'h21;
	// status and error bit positions
	localparam int ST_BUSY = 7;
	localparam int ST_RDY  = 6;
	localparam int ST_DRQ  = 3;
	localparam int ST_CORR = 2;
	localparam int ST_ERR  = 0;
	localparam int ER_UNC  = 6;
	localparam int ER_ABRT = 2;
	// unit_and_head_select fields
	localparam int DH_LBA   = 6;
	localparam int DH_DRIVE = 4;
	// sizes and reset values
	localparam logic [7:0]  WORDS_LAST   = 8'hFF;	// 256 words of 16 bits per sector
	localparam logic [8:0]  FULL_COUNT   = 9'h100;	// count of zero means 256
	localparam logic [7:0]  DEF_SPT      = 8'h01;	// sectors per track after reset
	localparam logic [3:0]  DEF_MAX_HEAD = 4'h0;	// highest head index after reset
	// sector word as it arrives from the media side
	typedef struct packed {
		logic [15:0] data;	// payload word
		logic        err;	// media error seen on this sector
		logic        corr;	// error was corrected
	} media_word_t;
	// task-file address fields
	typedef struct packed {
		logic [3:0] head;	// head or address 27..24
		logic [7:0] cyl_hi;	// address 23..16
		logic [7:0] cyl_lo;	// address 15..8
		logic [7:0] sec;	// address 7..0
	} taskaddr_t;
	typedef enum logic [1:0] {M_SINGLE, M_MULTI, M_DMA} rmode_t;
	typedef enum logic [2:0] {S_IDLE, S_IDLE_IMM, S_FETCH, S_XFER, S_DONE} state_t;
endpackage

/* test/ata_read_command_engine_tb_top.sv */
// testbench of the read command engine with a media source and a dma host
module ata_read_command_engine_tb_top import ata_read_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [7:0] op;
		logic       bm;
		logic [7:0] bs;
		logic       exp_err;
		logic       exp_idle;
	} abort_row_t;
	logic        core_clk, rst_n, reg_wr, reg_rd, byte_mode_en, dma_request_q;
	logic        dma_acknowledge_n, read_strobe_n, intrq_q, idle_state_q, fetch_req_q;
	logic        media_valid, media_ready_q, bad_corr, slow;
	logic        irq_prev = 1'b0;
	logic [2:0]  reg_addr;
	logic [7:0]  reg_wdata, multi_block_size;
	logic [7:0]  m_idx = 8'h00;
	logic [15:0] reg_rdata_q, dma_data_q, s;
	logic [27:0] fetch_addr_q, cur_addr, bad_addr;
	logic [31:0] dma_want, dma_count, dma_sum;
	media_word_t media_word;
	int          m_left = 0;
	int          words_sent = 0;
	int          irq_cnt = 0;
	int          words_read, base, fail_count, cmp_count, i0;
	logic [27:0] fetch_log[$];
	abort_row_t  rows[6];

	ata_read_command_engine #(.FIFO_DEPTH(8)) ata_read_command_engine_inst (
		.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
		.byte_mode_en(byte_mode_en), .multi_block_size(multi_block_size),
		.dma_request_q(dma_request_q), .dma_acknowledge_n(dma_acknowledge_n),
		.read_strobe_n(read_strobe_n), .dma_data_q(dma_data_q), .intrq_q(intrq_q),
		.idle_state_q(idle_state_q), .fetch_req_q(fetch_req_q), .fetch_addr_q(fetch_addr_q),
		.media_valid(media_valid), .media_word(media_word), .media_ready_q(media_ready_q));
	dma_host_model dma_host_model_inst (
		.core_clk(core_clk), .dma_request_q(dma_request_q), .dma_data_q(dma_data_q),
		.slow(slow), .words_wanted(dma_want), .dma_acknowledge_n(dma_acknowledge_n),
		.read_strobe_n(read_strobe_n), .word_count(dma_count), .word_sum(dma_sum));

	////////////////////////////////////////////////////////////////////////////////
	// 20 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	// media source: 256 words per fetch, word tagged with the low address byte
	assign media_valid = (m_left > 0);
	assign media_word  = '{data: {cur_addr[7:0], m_idx}, err: (cur_addr == bad_addr), corr: bad_corr};
	always @(posedge core_clk) begin
		logic fr, hs;
		logic [27:0] fa;
		fr = fetch_req_q;
		hs = media_valid && media_ready_q;
		fa = fetch_addr_q;
		if (intrq_q && !irq_prev) irq_cnt++;	// interrupt rises counted, not levels
		irq_prev = intrq_q;
		#1;
		if (fr) begin
			cur_addr = fa;
			m_left   = 256;
			m_idx    = 8'h00;
			fetch_log.push_back(fa);
		end else if (hs) begin
			m_left--;
			m_idx++;
			words_sent++;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// register strobes last one cycle and never touch the same time step twice
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		#1;
		reg_addr  = a;
		reg_wdata = d;
		reg_wr    = 1'b1;
		@(posedge core_clk);
		#1;
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge core_clk);
		#1;
		reg_addr = a;
		reg_rd   = 1'b1;
		@(posedge core_clk);
		#1;
		reg_rd = 1'b0;
		@(posedge core_clk);
		#1;
		d = reg_rdata_q;
	endtask
	// address and count first, opcode last
	task automatic issue(input logic [7:0] op, dh, hi, lo, sec, cnt);
		base = words_read;
		fetch_log.delete();
		i0 = irq_cnt;
		wr(OFS_SEC_CNT, cnt);
		wr(OFS_SEC_NUM, sec);
		wr(OFS_CYL_LO, lo);
		wr(OFS_CYL_HI, hi);
		wr(OFS_DEV_HEAD, dh);
		wr(OFS_CMD, op);
	endtask
	task automatic first_drq();
		for (int t = 0; t < 3000 && words_sent <= words_read; t++) @(posedge core_clk);
		repeat (2) @(posedge core_clk);
		rd(OFS_CMD, s);
		chk("busy and drq", 32'h0000_0001, {s[ST_BUSY], s[ST_DRQ]});
	endtask
	// pio words are read only once the media source has handed them over
	task automatic read_words(input int n);
		logic [15:0] d, e;
		for (int i = 0; i < n; i++) begin
			for (int t = 0; t < 3000 && words_sent <= words_read; t++) @(posedge core_clk);
			e = {fetch_log[(words_read - base) / 256][7:0], 8'((words_read - base) % 256)};
			rd(OFS_DATA, d);
			words_read++;
			chk("data word", e, d);
		end
	endtask
	task automatic chk_fetch(input logic [27:0] exp[$]);
		chk("fetch count", exp.size(), fetch_log.size());
		foreach (exp[i]) chk("fetch address", exp[i], fetch_log[i]);
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// watchdog, well past the ~15k cycles the sequence needs
	initial begin
		repeat (100000) @(posedge core_clk);
		fail_count++;
		complete_run();
	end
	initial begin
		rst_n = 1'b0;
		{reg_addr, reg_wr, reg_rd, reg_wdata, byte_mode_en} = '0;
		multi_block_size = 8'h00;
		bad_addr = '1;
		{bad_corr, slow} = 2'b00;
		dma_want = 32'h0000_0000;
		{words_read, fail_count, cmp_count} = '0;
		rows = '{'{8'h00, 1'b0, 8'h00, 1'b1, 1'b0}, '{OP_READ_DMA, 1'b1, 8'h01, 1'b1, 1'b0},
			'{OP_READ_MULTI, 1'b0, 8'h00, 1'b1, 1'b0}, '{OP_IDLE_IMM_A, 1'b0, 8'h00, 1'b0, 1'b1},
			'{OP_IDLE_IMM_B, 1'b0, 8'h00, 1'b0, 1'b1}, '{OP_INIT_GEOM, 1'b0, 8'h00, 1'b0, 1'b0}};
		repeat (20) @(posedge core_clk);
		#1;
		chk("intrq in reset", 32'h0000_0000, intrq_q);
		rst_n = 1'b1;
		rd(OFS_CMD, s);
		chk("status after reset", 32'h0000_0040, s[7:0]);
		wr(OFS_SEC_CNT, 8'h01);
		wr(OFS_DEV_HEAD, 8'hA0);
		// refused and short commands, one row each
		foreach (rows[r]) begin
			byte_mode_en     = rows[r].bm;
			multi_block_size = rows[r].bs;
			i0 = irq_cnt;
			wr(OFS_CMD, rows[r].op);
			repeat (3) @(posedge core_clk);
			chk("interrupt raised", i0 + 1, irq_cnt);
			chk("idle state", rows[r].exp_idle, idle_state_q);
			rd(OFS_CMD, s);
			chk("busy and error", {1'b0, rows[r].exp_err}, {s[ST_BUSY], s[ST_ERR]});
			rd(OFS_FEATURE, s);
			if (rows[r].exp_err) chk("aborted bit", 32'h0000_0001, s[ER_ABRT]);
		end
		byte_mode_en = 1'b0;
		// block address with a carry out of the low byte
		issue(OP_READ_SEC_A, 8'hE3, 8'h12, 8'h34, 8'hFF, 8'h02);
		first_drq();
		read_words(512);
		chk("pio interrupts", i0 + 2, irq_cnt);
		chk_fetch('{{4'h3, 8'h12, 8'h34, 8'hFF}, {4'h3, 8'h12, 8'h35, 8'h00}});
		rd(OFS_SEC_NUM, s);
		chk("last sector", 32'h0000_0000, s[7:0]);
		rd(OFS_CYL_LO, s);
		chk("last cyl low", 32'h0000_0035, s[7:0]);
		rd(OFS_DEV_HEAD, s);
		chk("unit head", 32'h0000_00E3, s[7:0]);
		// geometry of two sectors per track and two heads, then stepping
		wr(OFS_SEC_CNT, 8'h02);
		wr(OFS_DEV_HEAD, 8'hA1);
		wr(OFS_CMD, OP_INIT_GEOM);
		repeat (3) @(posedge core_clk);
		issue(OP_READ_SEC_B, 8'hA0, 8'h00, 8'h00, 8'h02, 8'h02);
		read_words(512);
		chk_fetch('{{4'h0, 8'h00, 8'h00, 8'h02}, {4'h1, 8'h00, 8'h00, 8'h01}});
		rd(OFS_DEV_HEAD, s);
		chk("last head", 32'h0000_0001, s[3:0]);
		// uncorrectable error on the second of three sectors
		bad_addr = {4'h0, 8'h00, 8'h01, 8'h01};
		issue(OP_READ_SEC_A, 8'hE0, 8'h00, 8'h01, 8'h00, 8'h03);
		read_words(512);
		chk_fetch('{{4'h0, 8'h00, 8'h01, 8'h00}, {4'h0, 8'h00, 8'h01, 8'h01}});
		rd(OFS_CMD, s);
		chk("error status", 32'h0000_0001, s[ST_ERR]);
		rd(OFS_FEATURE, s);
		chk("uncorrectable bit", 32'h0000_0001, s[ER_UNC]);
		rd(OFS_SEC_NUM, s);
		chk("failing sector", 32'h0000_0001, s[7:0]);
		// blocks of two over three sectors, correctable error in the first
		multi_block_size = 8'h02;
		bad_addr = {4'h0, 8'h00, 8'h02, 8'h00};
		bad_corr = 1'b1;
		issue(OP_READ_MULTI, 8'hE0, 8'h00, 8'h02, 8'h00, 8'h03);
		first_drq();
		chk("corrected posted", 32'h0000_0001, s[ST_CORR]);
		read_words(768);
		chk("block interrupts", i0 + 2, irq_cnt);
		chk_fetch('{{4'h0, 8'h00, 8'h02, 8'h00}, {4'h0, 8'h00, 8'h02, 8'h01},
			{4'h0, 8'h00, 8'h02, 8'h02}});
		// dma read of two sectors, slow host for the first one
		{bad_corr, slow} = 2'b01;
		bad_addr = '1;
		dma_want = 32'd512;
		issue(OP_READ_DMA, 8'hE0, 8'h00, 8'h03, 8'h00, 8'h02);
		first_drq();
		for (int t = 0; t < 20000 && dma_count < 512; t++) begin
			@(posedge core_clk);
			if (dma_count >= 256) slow = 1'b0;
		end
		repeat (8) @(posedge core_clk);
		chk("dma words", 32'd512, dma_count);
		chk("dma sum", 32'd130816, dma_sum);
		chk("dma interrupts", i0 + 1, irq_cnt);
		chk("dma request idle", 32'h0000_0000, dma_request_q);
		words_read = words_sent;
		// zero count opens a 256-sector read; a reset in mid-run must idle it
		issue(OP_READ_SEC_A, 8'hE0, 8'h00, 8'h04, 8'h00, 8'h00);
		first_drq();
		rst_n = 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		rd(OFS_CMD, s);
		chk("status after mid reset", 32'h0000_0040, s[7:0]);
		complete_run();
	end
endmodule

/* test/dma_host_model.sv */
// host side dma model: acknowledge held low, one read strobe pulse per word
module dma_host_model (
	input  wire logic        core_clk,
	input  wire logic        dma_request_q,
	input  wire logic [15:0] dma_data_q,
	input  wire logic        slow,
	input  wire logic [31:0] words_wanted,
	output logic             dma_acknowledge_n,
	output logic             read_strobe_n,
	output logic      [31:0] word_count,
	output logic      [31:0] word_sum
);
	timeunit 1ns;
	timeprecision 1ps;
	////////////////////////////////////////////////////////////////////////////////
	// one word per pass; the high phase outlasts the device's two-flop sync
	initial begin
		dma_acknowledge_n = 1'b1;
		read_strobe_n     = 1'b1;
		word_count        = 32'h0000_0000;
		word_sum          = 32'h0000_0000;
		forever begin
			@(posedge core_clk);
			#1;
			if (word_count >= words_wanted) begin
				dma_acknowledge_n = 1'b1;	// released once the transfer is whole
			end else if (dma_request_q && dma_acknowledge_n) begin
				dma_acknowledge_n = 1'b0;	// ack leads the first strobe
			end else if (dma_request_q) begin
				read_strobe_n = 1'b0;	// one low pulse per word
				repeat (4) @(posedge core_clk);
				word_sum   = word_sum + 32'(dma_data_q);	// data stable while low
				word_count = word_count + 1;	// 256 words make one sector
				#1;
				read_strobe_n = 1'b1;
				repeat (slow ? 12 : 6) @(posedge core_clk);	// slow host widens the gap
			end
		end
	end
endmodule
